// ==== src/fdi_regs.vh ====
// Frame layout constants for the frame deinterleaver.
// Assumes byte positions are 1-based within a frame.
`ifndef FDI_REGS_VH
`define FDI_REGS_VH
// ----------------------------------------
// Frame geometry
// ----------------------------------------
`define FDI_FRAME_BYTES   13'd5082
`define FDI_CHUNK_BYTES   9'd508
`define FDI_HEAD_BYTES    13'd6
`define FDI_TRIPLET_BYTES 9'd24
`define FDI_CHUNK_COUNT   4'd10
// ----------------------------------------
// Stand-alone byte positions
// ----------------------------------------
`define FDI_POS_IDENT     13'd1
`define FDI_POS_STATUS    13'd4
// ----------------------------------------
// Field-type tags
// ----------------------------------------
`define FDI_TAG_IDENT     3'd0
`define FDI_TAG_STATUS    3'd1
`define FDI_TAG_RADIO     3'd2
`define FDI_TAG_TIME      3'd3
`define FDI_TAG_IVAL      3'd4
`define FDI_TAG_QVAL      3'd5
// ----------------------------------------
// Reset values
// ----------------------------------------
`define FDI_RST_POS       13'd0
`endif

// ==== src/fdi_slot.v ====
// Classifies a byte position inside a 508-byte chunk.
// Assumes chunk position counts from 0 at the first chunk byte.
`include "fdi_regs.vh"
module fdi_slot
(
  // Position in chunk
  input  wire [8:0] chunk_pos,
  // Classification
  output reg        side_byte,
  output reg  [2:0] side_idx,
  output reg        sample_hi
);
  reg [8:0] rem;
  reg [8:0] q;
  always @*
  begin
    rem       = 9'h000;
    q         = 9'h000;
    side_byte = 1'b0;
    side_idx  = 3'h0;
    sample_hi = 1'b0;
    if (chunk_pos < `FDI_TRIPLET_BYTES)
    begin
      // Triplets: side byte then a two-byte sample
      q   = chunk_pos / 9'd3;
      rem = chunk_pos - q * 9'd3;
      side_byte = (rem == 9'h000);
      side_idx  = q[2:0];
      sample_hi = (rem == 9'h001);
    end
    else
    begin
      sample_hi = ~chunk_pos[0];
    end
  end
endmodule

// ==== src/fdi_frame_deinterleaver.v ====
// Frame deinterleaver: splits a 5082-byte frame into its fields.
// Assumes the byte source marks each first byte and is on mclk.
//
// Contract
// R1 - First time tag from bytes 22, 25, 28, high byte first, 24 bits.
// R2 - Each later time tag sits 508 bytes beyond the previous one.
// R3 - Remaining bytes are alternating I and Q, 16-bit, high first.
// R4 - Opening bytes: identifier, I1 high, I1 low, status, Q1 high, Q1 low.
// R5 - 508-byte chunks: 24 triplet bytes, then pure sample pairs.
// R6 - Nine more identical chunks; indices advance by one and 125.
// R7 - Tenth chunk ends after byte 504 with final pair 1250.
// R8 - Pair positions follow the slot and chunk base offset formula.
// R9 - High byte 0 to 127 is positive, else negative two's complement.
// R10 - Ten 40-bit radiometry values per frame.
// R11 - Exactly ten time tags per frame, one per chunk.
// R12 - Radiometry starts at byte 7, bytes every three, chunks 508 apart.
// R13 - Identifier is byte 1, status is byte 4, stand-alone.
// R14 - Frame is 5082 unsigned bytes numbered from 1.
// R15 - Start mark resets byte position and drops partial fields.
// R16 - Each field gets a one-cycle valid and type tag on last byte.
`include "fdi_regs.vh"
module fdi_frame_deinterleaver
(
  // Clock and reset
  input  wire        mclk,
  input  wire        rst,
  // Byte stream in
  input  wire        in_valid,
  input  wire        in_first,
  input  wire [7:0]  in_byte,
  // Field stream out
  output reg         fld_valid,
  output reg  [2:0]  fld_tag,
  output reg  [39:0] fld_data,
  output reg  [3:0]  fld_index,
  output reg  [10:0] fld_pair,
  output reg         fld_negative,
  // Status
  output reg         frame_done,
  output wire        frame_active
);

  // ----------------------------------------
  // Local constants
  // ----------------------------------------
  // Two states: waiting for a start mark, or inside a frame
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  // ----------------------------------------
  // Position tracking
  // ----------------------------------------
  reg         state;
  reg  [12:0] pos;
  reg  [8:0]  cpos;
  reg  [3:0]  chunk;
  reg  [10:0] pair;
  reg         q_turn;
  reg  [31:0] rad_acc;
  reg  [15:0] tt_acc;
  reg  [7:0]  hi_byte;
  wire [12:0] cur_pos;
  wire [8:0]  cur_cpos;
  wire [3:0]  cur_chunk;
  wire [10:0] cur_pair;
  wire        cur_q;
  wire        side_byte;
  wire [2:0]  side_idx;
  wire        sample_hi;
  wire        in_head;
  wire        take;
  wire        last_byte;
  wire        chunk_end;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  reg         next_state;
  reg  [12:0] next_pos;
  reg  [8:0]  next_cpos;
  reg  [3:0]  next_chunk;
  reg  [10:0] next_pair;
  reg         next_q_turn;
  reg  [31:0] next_rad_acc;
  reg  [15:0] next_tt_acc;
  reg  [7:0]  next_hi_byte;
  reg         next_fld_valid;
  reg  [2:0]  next_fld_tag;
  reg  [39:0] next_fld_data;
  reg  [3:0]  next_fld_index;
  reg  [10:0] next_fld_pair;
  reg         next_fld_negative;
  reg         next_frame_done;

  // ----------------------------------------
  // Current byte position
  // ----------------------------------------
  assign frame_active = (state == ST_RUN);
  // Start mark overrides any partial state
  assign cur_pos   = in_first ? `FDI_POS_IDENT : pos + 13'd1; // R15 R14
  assign in_head   = (cur_pos <= `FDI_HEAD_BYTES);
  assign cur_cpos  = (in_first | in_head) ? 9'h000 : cpos;
  assign cur_chunk = in_first ? 4'h0 : chunk;
  assign cur_pair  = in_first ? 11'd1 : pair;
  assign cur_q     = in_first ? 1'b0 : q_turn;
  // Unmarked bytes outside a frame are dropped, never buffered
  assign take      = in_valid & (frame_active | in_first);
  assign last_byte = (cur_pos == `FDI_FRAME_BYTES); // R7 R14
  assign chunk_end = (cur_cpos == `FDI_CHUNK_BYTES - 9'd1); // R6

  // ----------------------------------------
  // Sample word
  // ----------------------------------------
  wire [15:0] sample_word;
  wire        sample_neg;
  assign sample_word = {hi_byte, in_byte}; // R3
  assign sample_neg  = hi_byte[7]; // R9

  // ----------------------------------------
  // Byte classification inside a chunk
  // ----------------------------------------
  fdi_slot u_slot
  (
    .chunk_pos (cur_cpos),
    .side_byte (side_byte),
    .side_idx  (side_idx),
    .sample_hi (sample_hi)
  );

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  // Field registers hold between strobes; only the strobes self-clear
  always @*
  begin
    next_state        = state;
    next_pos          = pos;
    next_cpos         = cpos;
    next_chunk        = chunk;
    next_pair         = pair;
    next_q_turn       = q_turn;
    next_rad_acc      = rad_acc;
    next_tt_acc       = tt_acc;
    next_hi_byte      = hi_byte;
    next_fld_valid    = 1'b0;
    next_fld_tag      = fld_tag;
    next_fld_data     = fld_data;
    next_fld_index    = fld_index;
    next_fld_pair     = fld_pair;
    next_fld_negative = fld_negative;
    next_frame_done   = 1'b0;
    if (take)
    begin
      next_pos = cur_pos;
      if (in_first)
      begin
        // Partial fields discarded
        next_rad_acc = 32'h0000_0000; // R15
        next_tt_acc  = 16'h0000;
      end
      if (in_head)
      begin
        // Opening bytes
        case (cur_pos[2:0]) // R4
          3'd1:
          begin
            next_fld_valid = 1'b1; // R13 R16
            next_fld_tag   = `FDI_TAG_IDENT;
            next_fld_data  = {32'h0000_0000, in_byte};
          end
          3'd4:
          begin
            next_fld_valid = 1'b1; // R13 R16
            next_fld_tag   = `FDI_TAG_STATUS;
            next_fld_data  = {32'h0000_0000, in_byte};
          end
          3'd2, 3'd5:
            next_hi_byte = in_byte;
          3'd3:
          begin
            next_fld_valid    = 1'b1; // R3 R16
            next_fld_tag      = `FDI_TAG_IVAL;
            next_fld_data     = {24'h00_0000, sample_word};
            next_fld_pair     = 11'd1;
            next_fld_negative = sample_neg; // R9
          end
          3'd6:
          begin
            next_fld_valid    = 1'b1; // R3 R16
            next_fld_tag      = `FDI_TAG_QVAL;
            next_fld_data     = {24'h00_0000, sample_word};
            next_fld_pair     = 11'd1;
            next_fld_negative = sample_neg; // R9
          end
          default:
            next_hi_byte = hi_byte;
        endcase
        next_q_turn = 1'b0;
        next_pair   = (cur_pos == `FDI_HEAD_BYTES) ? 11'd2 : 11'd1;
        next_cpos   = 9'h000;
        next_chunk  = 4'h0;
        next_state  = ST_RUN;
      end
      else
      begin
        // Chunk bytes; slot order gives the pair offsets
        if (side_byte) // R5 R8
        begin
          // Shift loads; stale bytes fall out after four radiometry loads or two time-tag loads
          if (side_idx < 3'd4)
            next_rad_acc = {rad_acc[23:0], in_byte}; // R12
          else if (side_idx == 3'd4)
          begin
            next_fld_valid = 1'b1; // R10 R16
            next_fld_tag   = `FDI_TAG_RADIO;
            next_fld_data  = {rad_acc, in_byte};
            next_fld_index = cur_chunk + 4'h1;
          end
          else if (side_idx < 3'd7)
            next_tt_acc = {tt_acc[7:0], in_byte}; // R1 R2
          else
          begin
            next_fld_valid = 1'b1; // R11 R16
            next_fld_tag   = `FDI_TAG_TIME;
            next_fld_data  = {16'h0000, tt_acc, in_byte};
            next_fld_index = cur_chunk + 4'h1;
          end
        end
        else if (sample_hi)
          next_hi_byte = in_byte;
        else
        begin
          next_fld_valid    = 1'b1; // R3 R16
          next_fld_tag      = cur_q ? `FDI_TAG_QVAL : `FDI_TAG_IVAL;
          next_fld_data     = {24'h00_0000, sample_word};
          next_fld_pair     = cur_pair;
          next_fld_negative = sample_neg; // R9
          next_q_turn       = ~cur_q;
          if (cur_q)
            next_pair = cur_pair + 11'd1;
        end
        if (last_byte)
        begin
          // Tenth chunk stops short at byte 504
          next_frame_done = 1'b1; // R7 R14
          next_state      = ST_IDLE;
          next_cpos       = 9'h000;
          next_chunk      = 4'h0;
        end
        else if (chunk_end)
        begin
          next_cpos  = 9'h000; // R6
          next_chunk = cur_chunk + 4'h1;
        end
        else
          next_cpos = cur_cpos + 9'd1;
      end
    end
  end

  // ----------------------------------------
  // State and field registers
  // ----------------------------------------
  // Reset clears strobes on the next rising mclk edge so no stale field leaks out
  always @(posedge mclk)
  begin
    if (rst)
    begin
      state        <= ST_IDLE;
      pos          <= `FDI_RST_POS;
      cpos         <= 9'h000;
      chunk        <= 4'h0;
      pair         <= 11'd1;
      q_turn       <= 1'b0;
      rad_acc      <= 32'h0000_0000;
      tt_acc       <= 16'h0000;
      hi_byte      <= 8'h00;
      fld_valid    <= 1'b0;
      fld_tag      <= 3'h0;
      fld_data     <= 40'h00_0000_0000;
      fld_index    <= 4'h0;
      fld_pair     <= 11'd0;
      fld_negative <= 1'b0;
      frame_done   <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      pos          <= next_pos;
      cpos         <= next_cpos;
      chunk        <= next_chunk;
      pair         <= next_pair;
      q_turn       <= next_q_turn;
      rad_acc      <= next_rad_acc;
      tt_acc       <= next_tt_acc;
      hi_byte      <= next_hi_byte;
      fld_valid    <= next_fld_valid;
      fld_tag      <= next_fld_tag;
      fld_data     <= next_fld_data;
      fld_index    <= next_fld_index;
      fld_pair     <= next_fld_pair;
      fld_negative <= next_fld_negative;
      frame_done   <= next_frame_done;
    end
  end

endmodule

// ==== bench/fdi_props.sv ====
// Port checker for the frame deinterleaver.
// Assumes one mclk domain; bound at the foot.
module fdi_props
(
  // Clock and reset
  input wire        mclk,
  input wire        rst,
  // Byte stream in
  input wire        in_valid,
  input wire        in_first,
  input wire [7:0]  in_byte,
  // Field stream out
  input wire        fld_valid,
  input wire [2:0]  fld_tag,
  input wire [39:0] fld_data,
  input wire [3:0]  fld_index,
  input wire [10:0] fld_pair,
  input wire        fld_negative,
  // Status
  input wire        frame_done,
  input wire        frame_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_ident_first:
    assert property (in_valid && in_first |=> fld_valid && fld_tag == 3'h0
      && fld_data == {32'h0, $past(in_byte)}) else $error("ident field wrong");
  a_strobe_cause:
    assert property (fld_valid |-> $past(in_valid)) else $error("strobe without byte");
  a_sign_bit:
    assert property (fld_valid && fld_tag >= 3'h4 |-> fld_negative == fld_data[15]
      && fld_data[39:16] == 24'h0) else $error("sample sign wrong");
  a_time_width:
    assert property (fld_valid && fld_tag == 3'h3 |-> fld_data[39:24] == 16'h0
      && fld_index inside {[4'h1:4'ha]}) else $error("time tag wrong");
  a_pair_range:
    assert property (fld_valid && fld_tag >= 3'h4 |-> fld_pair inside {[11'h1:11'h4e2]})
      else $error("pair index wrong");
  a_done_pulse:
    assert property (frame_done |-> !frame_active ##1 !frame_done) else $error("done wrong");
  a_done_last:
    assert property (frame_done |-> fld_valid && fld_tag == 3'h5 && fld_pair == 11'h4e2)
      else $error("last pair wrong");
  a_idle_quiet:
    assert property (!frame_active && !in_first |=> !fld_valid) else $error("idle strobe");
  a_active_start:
    assert property (in_valid && in_first |=> frame_active) else $error("frame not started");
  c_done: cover property (frame_done);
  c_radio: cover property (fld_valid && fld_tag == 3'h2);
  c_neg: cover property (fld_valid && fld_negative);
endmodule
bind fdi_frame_deinterleaver fdi_props u_props (.mclk, .rst, .in_valid, .in_first,
  .fld_valid, .fld_negative, .frame_done, .frame_active, .in_byte, .fld_tag,
  .fld_data, .fld_index, .fld_pair);

// ==== bench/fdi_src.sv ====
// Frame byte source model for the deinterleaver input.
// Assumes send is entered just after a rising mclk edge.
module fdi_src (
  input  wire logic mclk,
  output logic       in_valid = 1'b0,
  output logic       in_first = 1'b0,
  output logic [7:0] in_byte = 8'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  function automatic logic [7:0] pat(input int n);
    return n[7:0] ^ n[12:5];
  endfunction
  // Idle data inverted so stale bytes never pass as fresh
  task automatic send(input int len, input bit gap, input bit mark);
    for (int n = 1; n <= len; n++)
    begin
      in_valid <= 1'b1;
      in_first <= mark && n == 1;
      in_byte  <= pat(n);
      @(posedge mclk);
      if (gap && n % 5 == 0)
      begin
        in_valid <= 1'b0;
        in_byte  <= ~pat(n);
        @(posedge mclk);
      end
    end
    in_valid <= 1'b0;
    in_first <= 1'b0;
    in_byte  <= ~pat(len);
  endtask
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the frame deinterleaver.
// Assumes the source model and bound checker are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic in_valid, in_first, fld_valid, fld_negative, frame_done, frame_active;
  logic [7:0] in_byte;
  logic [2:0] fld_tag;
  logic [39:0] fld_data;
  logic [3:0] fld_index;
  logic [10:0] fld_pair;
  int failures = 0, n_tests = 0, n_fld = 0, n_done = 0;
  int exp_pair = 1, exp_idx = 1;
  fdi_src src (.mclk, .in_valid, .in_first, .in_byte);
  fdi_frame_deinterleaver dut (.mclk, .rst, .in_valid, .in_first, .in_byte, .fld_valid,
    .fld_tag, .fld_data, .fld_index, .fld_pair, .fld_negative, .frame_done, .frame_active);
  initial forever #50 mclk = ~mclk;
  function automatic logic [39:0] want(input logic [2:0] t, input int i, input int k);
    int b, m, p;
    b = 508 * (i - 1);
    m = (k + 123) % 125;
    p = m < 4 ? 8 + 6 * m : 15 + 4 * m;
    p = k == 1 ? 2 : p + 508 * ((k + 123 - m) / 125 - 1);
    if (t == 3'h5) p = p + (k == 1 || m < 4 ? 3 : 2);
    case (t)
      3'h0: return {32'h0, src.pat(1)};
      3'h1: return {32'h0, src.pat(4)};
      3'h2: return {src.pat(7+b), src.pat(10+b), src.pat(13+b), src.pat(16+b), src.pat(19+b)};
      3'h3: return {16'h0, src.pat(22+b), src.pat(25+b), src.pat(28+b)};
      default: return {24'h0, src.pat(p), src.pat(p + 1)};
    endcase
  endfunction
  always @(posedge mclk)
  begin
    if (frame_done === 1'b1) n_done++;
    if (fld_valid === 1'b1)
    begin
      n_fld++;
      if (fld_tag === 3'h0)
      begin
        exp_pair = 1;
        exp_idx = 1;
      end
      if (fld_tag >= 3'h4)
        check(fld_pair, exp_pair);
      if (fld_tag == 3'h5)
        exp_pair++;
      if (fld_tag == 3'h2)
        check(fld_index, exp_idx);
      if (fld_tag == 3'h3)
      begin
        check(fld_index, exp_idx);
        exp_idx++;
      end
      n_tests++;
      if (fld_data !== want(fld_tag, fld_index, fld_pair))
      begin
        failures++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, fld_data,
          want(fld_tag, fld_index, fld_pair));
      end
    end
  end
  task automatic check(input int got, input int exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic t_frame(input bit gap);
    n_fld = 0;
    n_done = 0;
    src.send(5082, gap, 1'b1);
    repeat (3) @(posedge mclk);
    check(n_fld, 2522);
    check(n_done, 1);
  endtask
  // Partial radiometry must not leak into the restarted frame
  task automatic t_restart;
    src.send(13, 1'b0, 1'b1);
    @(posedge mclk);
    t_frame(1'b0);
  endtask
  task automatic t_idle;
    n_fld = 0;
    src.send(40, 1'b0, 1'b0);
    repeat (3) @(posedge mclk);
    check(n_fld, 0);
  endtask
  // Reset mid-frame must leave the block idle and deaf to unmarked bytes
  task automatic t_reset;
    src.send(9, 1'b0, 1'b1);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    n_fld = 0;
    src.send(20, 1'b0, 1'b0);
    repeat (3) @(posedge mclk);
    check(n_fld, 0);
    check(frame_active !== 1'b0, 0);
  endtask
  task automatic report_and_stop;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_frame(1'b0);
    t_frame(1'b1);
    t_restart;
    t_idle;
    t_reset;
    report_and_stop;
  end
  initial
  begin
    #(30000 * 100);
    failures++;
    report_and_stop;
  end
endmodule
